// ==== hdl/i2c_mem_target.sv ====
// Serial-bus target logic of an 8K x 8 byte memory.
// Assumes the bus clock and data pins are open-drain and
// asynchronous; the bus clock runs far below the system clock.
//
// Overview of operation
// - Acknowledge and store unlimited write data bytes
// - Write address wraps from top to zero
// - No busy period; always ready to answer
// - Commit byte at eighth bit, before acknowledge
// - START or STOP before eighth bit aborts byte
// - Write-protect high: data bytes get no acknowledge
// - Rejected protected byte leaves address unchanged
// - Write-protect low or floating disables protection
// - Direction bit one starts read at current address
// - Read starts at latched or following address
// - Address advances after every read byte
// - Controller acknowledge fetches next sequential byte
// - Unterminated read keeps driving further bytes
// - Read address wraps from top to zero
// - Address bytes load latch before data arrives
// - Repeated START after address gives selective read
// - Thirteen-bit address; upper three bits ignored
// - Target byte: type, select bits, direction bit
// - Address increments just before acknowledge clock
// - All bytes travel most significant bit first
`timescale 1ns/1ps
`default_nettype none

module i2c_mem_target #(
   // Device-type code; value is arbitrary
   parameter logic [3:0] DEV_TYPE = 4'h6
) (
   input  wire logic       clock,   // System clock
   input  wire logic       arst_n,  // Async reset, low
   input  wire logic       sclIn,   // Bus clock pin
   input  wire logic       sdaIn,   // Bus data pin level
   output logic            sdaOut,  // Data drive value
   output logic            sdaOe,   // Pull data pin low
   input  wire logic       wpIn,    // Write-protect pin
   input  wire logic [2:0] selIn    // Select pins
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic                 sclS;
   logic                 sdaS;
   logic                 wpS;
   logic [2:0]           selS;
   logic                 sclPrev_r;
   logic                 sdaPrev_r;
   logic                 sclRise;
   logic                 sclFall;
   logic                 startCond;
   logic                 stopCond;
   i2c_mem_pkg::state_t  state_r;
   logic                 active;
   logic [3:0]           bitCnt_r;
   logic                 ninth_r;
   logic                 ackPend_r;
   logic [7:0]           rxByte_r;
   logic [7:0]           rxNow;
   logic                 byteEnd;
   logic                 ackClock;
   logic                 match;
   logic                 wrOk;
   logic                 push;
   logic [12:0]          addr_r;
   logic [4:0]           addrHi_r;
   logic [7:0]           txByte_r;
   logic                 loadTx;
   logic [7:0]           memRd;
   logic [7:0]           mem_r [i2c_mem_pkg::MEM_DEPTH];
   logic                 fifoInReady;
   logic                 fifoOutValid;
   logic [20:0]          fifoOut;
   logic                 drain;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   sync2 #(
      .WIDTH (2),
      .INIT  ('1)
   ) busSync (
      .clock  (clock),
      .arst_n (arst_n),
      .din    ({sclIn, sdaIn}),
      .dout   ({sclS, sdaS})
   );

   sync2 #(
      .WIDTH (4)
   ) pinSync (
      .clock  (clock),
      .arst_n (arst_n),
      .din    ({wpIn, selIn}),
      .dout   ({wpS, selS})
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus conditions

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclPrev_r <= sclS;
         sdaPrev_r <= sdaS;
      end
   end

   assign sclRise   = sclS && !sclPrev_r;
   assign sclFall   = !sclS && sclPrev_r;
   assign startCond = sclS && sclPrev_r && sdaPrev_r && !sdaS;
   assign stopCond  = sclS && sclPrev_r && !sdaPrev_r && sdaS;

   assign active  = (state_r != i2c_mem_pkg::ST_IDLE)
                 && (state_r != i2c_mem_pkg::ST_IGNORE);
   assign rxNow    = {rxByte_r[6:0], sdaS};
   assign byteEnd  = active && sclRise
                  && (bitCnt_r == i2c_mem_pkg::BIT_LAST);
   assign ackClock = active && sclRise
                  && (bitCnt_r == i2c_mem_pkg::BIT_ACK);

   assign match = (rxNow[i2c_mem_pkg::TYPE_MSB:i2c_mem_pkg::TYPE_LSB]
                   == DEV_TYPE)
               && (rxNow[i2c_mem_pkg::SEL_MSB:i2c_mem_pkg::SEL_LSB]
                   == selS);

   assign wrOk = !wpS && fifoInReady;
   assign push = byteEnd && (state_r == i2c_mem_pkg::ST_WR) && wrOk;

   ////////////////////////////////////////////////////////////////////////
   // Byte role state

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= i2c_mem_pkg::ST_IDLE;
      end else if (startCond) begin
         state_r <= i2c_mem_pkg::ST_DEV;
      end else if (stopCond) begin
         state_r <= i2c_mem_pkg::ST_IDLE;
      end else if (byteEnd) begin
         case (state_r)
            i2c_mem_pkg::ST_DEV: begin
               if (!match) begin
                  state_r <= i2c_mem_pkg::ST_IGNORE;
               end else if (rxNow[i2c_mem_pkg::DIR_BIT]) begin
                  state_r <= i2c_mem_pkg::ST_RD;
               end else begin
                  state_r <= i2c_mem_pkg::ST_AHI;
               end
            end
            i2c_mem_pkg::ST_AHI: begin
               state_r <= i2c_mem_pkg::ST_ALO;
            end
            i2c_mem_pkg::ST_ALO: begin
               state_r <= i2c_mem_pkg::ST_WR;
            end
            default: begin
               state_r <= state_r;
            end
         endcase
      end else if (ackClock && (state_r == i2c_mem_pkg::ST_RD)
                   && !ackPend_r && sdaS) begin
         state_r <= i2c_mem_pkg::ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit counting

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bitCnt_r <= i2c_mem_pkg::BIT_FIRST;
      end else if (startCond || stopCond) begin
         bitCnt_r <= i2c_mem_pkg::BIT_FIRST;
      end else if (ackClock) begin
         bitCnt_r <= i2c_mem_pkg::BIT_FIRST;
      end else if (active && sclRise) begin
         bitCnt_r <= bitCnt_r + i2c_mem_pkg::BIT_ONE;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rxByte_r <= '0;
      end else if (active && sclRise) begin
         rxByte_r <= rxNow;
      end
   end

   // Marks the high phase of the acknowledge clock
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ninth_r <= 1'b0;
      end else if (startCond || stopCond || sclFall) begin
         ninth_r <= 1'b0;
      end else if (ackClock) begin
         ninth_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acknowledge decision, taken at the eighth bit

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ackPend_r <= 1'b0;
      end else if (startCond || stopCond) begin
         ackPend_r <= 1'b0;
      end else if (byteEnd) begin
         case (state_r)
            i2c_mem_pkg::ST_DEV: begin
               ackPend_r <= match;
            end
            i2c_mem_pkg::ST_AHI,
            i2c_mem_pkg::ST_ALO: begin
               ackPend_r <= 1'b1;
            end
            i2c_mem_pkg::ST_WR: begin
               ackPend_r <= wrOk;
            end
            default: begin
               ackPend_r <= 1'b0;
            end
         endcase
      end else if (sclFall && ninth_r) begin
         ackPend_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address latch

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         addrHi_r <= '0;
      end else if (byteEnd && (state_r == i2c_mem_pkg::ST_AHI)) begin
         addrHi_r <= rxNow[i2c_mem_pkg::ADDR_HI_W-1:0];
      end
   end

   // Latch survives START and STOP so a later read resumes here
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         addr_r <= i2c_mem_pkg::ADDR_ZERO;
      end else if (byteEnd && (state_r == i2c_mem_pkg::ST_ALO)) begin
         addr_r <= {addrHi_r, rxNow};
      end else if (push) begin
         addr_r <= addr_r + i2c_mem_pkg::ADDR_ONE;
      end else if (byteEnd && (state_r == i2c_mem_pkg::ST_RD)) begin
         addr_r <= addr_r + i2c_mem_pkg::ADDR_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit byte

   assign memRd  = mem_r[addr_r];
   assign loadTx = sclFall && ninth_r
                && (state_r == i2c_mem_pkg::ST_RD);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         txByte_r <= '0;
      end else if (loadTx) begin
         txByte_r <= memRd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data pin drive, changed only on falling bus clock edges

   assign sdaOut = 1'b0;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sdaOe <= 1'b0;
      end else if (startCond || stopCond) begin
         sdaOe <= 1'b0;
      end else if (sclFall) begin
         if (loadTx) begin
            sdaOe <= !memRd[i2c_mem_pkg::DATA_W-1];
         end else if (ninth_r) begin
            sdaOe <= 1'b0;
         end else if (bitCnt_r == i2c_mem_pkg::BIT_ACK) begin
            sdaOe <= ackPend_r;
         end else if ((state_r == i2c_mem_pkg::ST_RD)
                      && (bitCnt_r != i2c_mem_pkg::BIT_FIRST)) begin
            sdaOe <= !txByte_r[3'(i2c_mem_pkg::BIT_LAST - bitCnt_r)];
         end else begin
            sdaOe <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write buffer and array

   sync_fifo #(
      .WIDTH (i2c_mem_pkg::FIFO_W),
      .DEPTH (i2c_mem_pkg::FIFO_DEPTH)
   ) wrBuf (
      .clock    (clock),
      .arst_n   (arst_n),
      .inData   ({addr_r, rxNow}),
      .inValid  (push),
      .inReady  (fifoInReady),
      .outData  (fifoOut),
      .outValid (fifoOutValid),
      .outReady (!loadTx)
   );

   // The array has one port; a fetch stalls the drain for a
   // cycle, so a full buffer turns into a refused byte.
   assign drain = fifoOutValid && !loadTx;

   always_ff @(posedge clock) begin
      if (drain) begin
         mem_r[fifoOut[i2c_mem_pkg::FIFO_W-1:i2c_mem_pkg::DATA_W]] <= fifoOut[i2c_mem_pkg::DATA_W-1:0];
      end
   end

endmodule : i2c_mem_target

`default_nettype wire

// ==== hdl/i2c_mem_pkg.sv ====
// Constants, field layout and states of the serial memory target.
// Assumes one system clock far faster than the bus clock.
package i2c_mem_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Array and address
   localparam int          DATA_W    = 8;
   localparam int          ADDR_W    = 13;
   localparam int          MEM_DEPTH = 8192;
   localparam int          ADDR_HI_W = 5;
   localparam logic [12:0] ADDR_TOP  = 13'h1FFF;
   localparam logic [12:0] ADDR_ZERO = 13'h0000;
   localparam logic [12:0] ADDR_ONE  = 13'h0001;

   ////////////////////////////////////////////////////////////////////////
   // Target byte fields
   localparam int DIR_BIT  = 0;
   localparam int SEL_LSB  = 1;
   localparam int SEL_MSB  = 3;
   localparam int TYPE_LSB = 4;
   localparam int TYPE_MSB = 7;

   ////////////////////////////////////////////////////////////////////////
   // Bit counter values within a byte
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_ONE   = 4'h1;
   localparam logic [3:0] BIT_LAST  = 4'h7;
   localparam logic [3:0] BIT_ACK   = 4'h8;

   ////////////////////////////////////////////////////////////////////////
   // Write buffer: address and data travel together
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W     = ADDR_W + DATA_W;

   // Role of the byte in flight, Gray coded along the usual path
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_DEV    = 3'h1,
      ST_AHI    = 3'h3,
      ST_ALO    = 3'h2,
      ST_WR     = 3'h6,
      ST_RD     = 3'h7,
      ST_IGNORE = 3'h5
   } state_t;

endpackage : i2c_mem_pkg

// ==== hdl/sync2.sv ====
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit changes slowly against the clock.
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
   parameter int               WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   input  wire logic             clock,  // System clock
   input  wire logic             arst_n, // Async reset, low
   input  wire logic [WIDTH-1:0] din,    // Asynchronous levels
   output logic      [WIDTH-1:0] dout    // Synchronised levels
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         // Reset to the pins' idle level so no false edge follows
         meta_r <= INIT;
         dout   <= INIT;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule : sync2

`default_nettype wire

// ==== hdl/sync_fifo.sv ====
// Single-clock FIFO of flip-flops with valid/ready on both sides.
// Assumes producer and consumer share the clock.
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,    // System clock
   input  wire logic             arst_n,   // Async reset, low
   input  wire logic [WIDTH-1:0] inData,   // Word to store
   input  wire logic             inValid,  // Word offered
   output logic                  inReady,  // Room left
   output logic      [WIDTH-1:0] outData,  // Oldest word
   output logic                  outValid, // Word waiting
   input  wire logic             outReady  // Consumer takes
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_r [DEPTH];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   logic             push;
   logic             pop;

   assign outValid = (wrPtr_r != rdPtr_r);
   assign inReady  = !((wrPtr_r[AW] != rdPtr_r[AW])
                     && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]));
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = store_r[rdPtr_r[AW-1:0]];

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (push) begin
         store_r[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end

endmodule : sync_fifo

`default_nettype wire

// ==== tb/i2c_mem_target_monitor.sv ====
// Pin-level checker for the serial memory target.
// Assumes the bus clock runs far slower than the system clock.
`timescale 1ns/1ps
`default_nettype none

module i2c_mem_target_monitor #(
   parameter logic [3:0] DEV_TYPE = 4'h6
) (
   input wire logic       clock,  // System clock
   input wire logic       arst_n, // Async reset, low
   input wire logic       sclIn,  // Bus clock pin
   input wire logic       sdaIn,  // Bus data wire
   input wire logic       sdaOut, // Data drive value
   input wire logic       sdaOe,  // Data pull enable
   input wire logic       wpIn,   // Write protect
   input wire logic [2:0] selIn   // Select pins
);
   logic       sclD_r, sdaD_r, dir_r, hit_r, ignore_r;
   logic [3:0] bitCnt_r, lowCnt_r;
   logic [1:0] byteCnt_r;
   logic [6:0] shift_r;
   wire        rise  = sclIn & !sclD_r;
   // Data moving while the clock is high can only be START or STOP
   wire        edgeS = sclIn & sclD_r & (sdaD_r ^ sdaIn);
   wire        ack9  = rise && bitCnt_r == 4'h8;
   wire  [7:0] tByte = {shift_r, sdaIn};

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sclD_r <= 1'b1;
         sdaD_r <= 1'b1;
      end else begin
         sclD_r <= sclIn;
         sdaD_r <= sdaIn;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bitCnt_r  <= 4'h0;
         byteCnt_r <= 2'h0;
         shift_r   <= 7'h00;
      end else if (edgeS) begin
         bitCnt_r  <= 4'h0;
         byteCnt_r <= 2'h0;
      end else if (rise) begin
         shift_r  <= tByte[6:0];
         bitCnt_r <= (bitCnt_r == 4'h8) ? 4'h0 : bitCnt_r + 4'h1;
         if (bitCnt_r == 4'h8 && byteCnt_r != 2'h3) begin
            byteCnt_r <= byteCnt_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dir_r    <= 1'b0;
         hit_r    <= 1'b0;
         ignore_r <= 1'b0;
      end else if (edgeS) begin
         ignore_r <= 1'b0;
      end else if (rise && byteCnt_r == 2'h0 && bitCnt_r == 4'h7) begin
         dir_r <= sdaIn;
         hit_r <= tByte[7:4] == DEV_TYPE && tByte[3:1] == selIn;
      end else if (ack9 && byteCnt_r == 2'h0) begin
         ignore_r <= !hit_r;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lowCnt_r <= 4'h0;
      end else if (sclIn) begin
         lowCnt_r <= 4'h0;
      end else if (lowCnt_r != 4'hF) begin
         lowCnt_r <= lowCnt_r + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   property p_ack_hit; ack9 && byteCnt_r == 2'h0 && hit_r |-> sdaOe; endproperty
   a_ack_hit: assert property (p_ack_hit) else $error("target byte not acknowledged");
   property p_miss_nack; ack9 && byteCnt_r == 2'h0 && !hit_r |-> !sdaOe; endproperty
   a_miss_nack: assert property (p_miss_nack) else $error("foreign target byte acknowledged");
   property p_ignore_quiet; ignore_r |-> !sdaOe; endproperty
   a_ignore_quiet: assert property (p_ignore_quiet) else $error("data driven while deselected");
   property p_addr_ack;
      ack9 && hit_r && !dir_r && (byteCnt_r == 2'h1 || byteCnt_r == 2'h2) |-> sdaOe;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address byte not acknowledged");
   property p_wp_nack; ack9 && hit_r && !dir_r && byteCnt_r == 2'h3 && wpIn |-> !sdaOe; endproperty
   a_wp_nack: assert property (p_wp_nack) else $error("protected byte acknowledged");
   property p_data_ack; ack9 && hit_r && !dir_r && byteCnt_r == 2'h3 && !wpIn |-> sdaOe; endproperty
   a_data_ack: assert property (p_data_ack) else $error("write data not acknowledged");
   property p_rd_release; ack9 && hit_r && dir_r && byteCnt_r != 2'h0 |-> !sdaOe; endproperty
   a_rd_release: assert property (p_rd_release) else $error("read ack slot not released");
   property p_oe_lag; $changed(sdaOe) |-> lowCnt_r >= 4'h2 && lowCnt_r <= 4'h6; endproperty
   a_oe_lag: assert property (p_oe_lag) else $error("data drive changed off the low phase");
   property p_hold_high; sclIn && sclD_r |-> $stable(sdaOe); endproperty
   a_hold_high: assert property (p_hold_high) else $error("data drive moved while clock high");

   c_wp: cover property (ack9 && byteCnt_r == 2'h3 && wpIn);
   c_ignore: cover property (ignore_r);
   c_read: cover property (ack9 && dir_r && hit_r);
endmodule : i2c_mem_target_monitor

bind i2c_mem_target i2c_mem_target_monitor #(.DEV_TYPE(DEV_TYPE)) mon (
   .clock(clock), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .wpIn(wpIn), .selIn(selIn)
);
`default_nettype wire

// ==== tb/i2c_ctrl_model.sv ====
// Bus controller model: drives the serial clock and pulls data low.
// Assumes a pull-up on the data wire; the clock stays high between frames.
`timescale 1ns/1ps
`default_nettype none

module i2c_ctrl_model (
   input  wire logic clock, // System clock
   input  wire logic sda,   // Resolved data wire
   output logic      scl,   // Bus clock
   output logic      pull,  // Pull data low
   output logic [8:0] seen, // Last byte and ack bit
   output logic      seenV  // Pulse, seen updated
);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
      seen = 9'h000;
      seenV = 1'b0;
   end

   // Quarter of the 160 ns bus period
   task automatic quarter;
      repeat (5) @(posedge clock);
   endtask : quarter

   task automatic startC;
      pull <= 1'b0;
      quarter();
      scl <= 1'b1;
      quarter();
      pull <= 1'b1;
      quarter();
      scl <= 1'b0;
      quarter();
   endtask : startC

   task automatic stopC;
      pull <= 1'b1;
      quarter();
      scl <= 1'b1;
      quarter();
      pull <= 1'b0;
      quarter();
   endtask : stopC

   // Top bit first; fewer than 9 bits leaves a byte unfinished
   task automatic byteIo(input logic [8:0] d, input int n);
      logic [8:0] r;
      r = 9'h1FF;
      for (int i = 8; i > 8 - n; i--) begin
         pull <= !d[i];
         quarter();
         scl <= 1'b1;
         quarter();
         r[i] = sda;
         quarter();
         scl <= 1'b0;
         quarter();
      end
      if (n == 9) begin
         seen <= r;
         seenV <= 1'b1;
         @(posedge clock);
         seenV <= 1'b0;
      end
   endtask : byteIo
endmodule : i2c_ctrl_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial memory target.
// Assumes the controller model and checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_top;
   localparam logic [3:0] DEVT = 4'h9; // Arbitrary device-type code
   typedef struct packed { logic [8:0] v; logic [8:0] m; } note_t;
   logic       clock = 1'b0, arst_n = 1'b0, wpIn = 1'b0;
   logic [2:0] selIn = 3'h0;
   logic       scl, pull, seenV, sdaOut, sdaOe;
   logic [8:0] seen;
   wire logic  sda = !(pull || (sdaOe && !sdaOut));
   logic [7:0] mem [logic [12:0]];
   logic [12:0] cur, a;
   note_t      notes [$];
   note_t      e;
   int         err_total = 0, n_compared = 0;

   i2c_mem_target #(.DEV_TYPE(DEVT)) uut (.clock(clock), .arst_n(arst_n), .sclIn(scl),
      .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .wpIn(wpIn), .selIn(selIn));
   i2c_ctrl_model ctl (.clock(clock), .sda(sda), .scl(scl), .pull(pull), .seen(seen), .seenV(seenV));

   always #4 clock = ~clock;

   always @(posedge clock) begin
      if (seenV === 1'b1) begin
         `CHK("pending note", 1'b1, notes.size() != 0)
         if (notes.size() != 0) begin
            e = notes.pop_front();
            `CHK("bus byte", e.v & e.m, seen & e.m)
         end
      end
   end

   task automatic wr(input logic [7:0] d, input logic ack);
      notes.push_back('{{8'h00, !ack}, 9'h001});
      ctl.byteIo({d, 1'b1}, 9);
   endtask : wr

   task automatic rd(input logic last);
      notes.push_back('{{mem[cur], last}, 9'h1FE});
      ctl.byteIo({8'hFF, last}, 9);
      cur++;
   endtask : rd

   task automatic tgt(input logic rdDir);
      ctl.startC();
      wr({DEVT, selIn, rdDir}, 1'b1);
   endtask : tgt

   // Write opening, upper address bits junk
   task automatic seek(input logic [12:0] ad);
      tgt(1'b0);
      wr({3'b101, ad[12:8]}, 1'b1);
      wr(ad[7:0], 1'b1);
      cur = ad;
   endtask : seek

   task automatic wdat(input logic [7:0] d);
      wr(d, !wpIn);
      if (!wpIn) begin
         mem[cur] = d;
         cur++;
      end
   endtask : wdat

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   initial begin
      repeat (60000) @(posedge clock);
      err_total++;
      $display("[FAIL] watchdog exp done got running");
      end_sim();
   end

   initial begin
      void'($urandom(98039));
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      selIn <= 3'($urandom);
      repeat (4) @(posedge clock);
      a = 13'($urandom);
      seek(a);
      repeat (4) wdat(8'($urandom));
      ctl.stopC();
      seek(a);
      tgt(1'b1);
      repeat (3) rd(1'b0);
      rd(1'b1);
      ctl.stopC();
      // Wrap both ways, then current address
      seek(13'h1FFE);
      repeat (4) wdat(8'($urandom));
      seek(13'h1FFF);
      tgt(1'b1);
      rd(1'b0);
      rd(1'b1);
      ctl.stopC();
      tgt(1'b1);
      rd(1'b1);
      ctl.stopC();
      // Abort by STOP, then by repeated START
      // The condition's own clock must stay short of the eighth bit
      for (int k = 0; k < 2; k++) begin
         seek(a);
         ctl.byteIo({~mem[a], 1'b1}, 5 + k);
         if (k == 0) begin
            ctl.stopC();
            seek(a);
         end
         tgt(1'b1);
         rd(1'b1);
         ctl.stopC();
      end
      seek(a);
      wpIn <= 1'b1;
      @(posedge clock);
      repeat (2) wdat(8'($urandom));
      wpIn <= 1'b0;
      @(posedge clock);
      wdat(8'($urandom));
      seek(a);
      tgt(1'b1);
      rd(1'b1);
      ctl.stopC();
      for (int k = 0; k < 4; k++) begin
         selIn <= 3'($urandom);
         @(posedge clock);
         ctl.startC();
         wr({DEVT ^ 4'(k >> 1), selIn ^ 3'(k & 1), 1'b0}, k == 0);
         wr(8'h00, k == 0);
         ctl.stopC();
      end
      seek(a);
      tgt(1'b1);
      ctl.byteIo(9'h1FF, 8);
      ctl.stopC();
      cur++;
      tgt(1'b1);
      rd(1'b1);
      tgt(1'b1);
      ctl.byteIo(9'h1FF, 8);
      cur++;
      tgt(1'b1);
      rd(1'b1);
      ctl.stopC();
      for (int i = 0; i < 50 && notes.size() != 0; i++) @(posedge clock);
      `CHK("notes left", 0, notes.size())
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
